// File: src/tcop_cfg.svh
// constants for the timer compare and single-pulse block
// assumes inclusion by bare name from the main module and the prescaler
`ifndef TCOP_CFG_SVH
`define TCOP_CFG_SVH
// register byte addresses on the register bus
`define TCOP_ADDR_CTRL_A   8'h00
`define TCOP_ADDR_CTRL_B   8'h04
`define TCOP_ADDR_STATUS   8'h08
`define TCOP_ADDR_CMP1_HI  8'h0c
`define TCOP_ADDR_CMP1_LO  8'h10
`define TCOP_ADDR_CMP2_HI  8'h14
`define TCOP_ADDR_CMP2_LO  8'h18
`define TCOP_ADDR_CAP1_HI  8'h1c
`define TCOP_ADDR_CAP1_LO  8'h20
`define TCOP_ADDR_CAP2_HI  8'h24
`define TCOP_ADDR_CAP2_LO  8'h28
`define TCOP_ADDR_COUNT    8'h2c
`define TCOP_ADDR_CPUFLAGS 8'h30
// control register a fields
`define TCOP_A_CAP_IE      7
`define TCOP_A_CMP_IE      6
`define TCOP_A_LVL2        1
`define TCOP_A_LVL1        0
`define TCOP_A_EDGE1       2
`define TCOP_A_EDGE2       3
`define TCOP_A_FORCE1      4
`define TCOP_A_FORCE2      5
// control register b fields
`define TCOP_B_PIN1_EN     0
`define TCOP_B_PIN2_EN     1
`define TCOP_B_PWM         2
`define TCOP_B_SPULSE      3
`define TCOP_B_CKSEL_LO    4
`define TCOP_B_CKSEL_HI    5
// status register fields
`define TCOP_S_CAP1        0
`define TCOP_S_CAP2        1
`define TCOP_S_CMP1        2
`define TCOP_S_CMP2        3
// reset and reload values, external clock select and bus response codes
`define TCOP_CMP_RESET     16'h8000
`define TCOP_CNT_RELOAD    16'hfffc
`define TCOP_CAP_TRIGGER   16'hfffd
`define TCOP_CKSEL_EXT     2'b11
`define TCOP_BUS_OKAY      2'b00
`define TCOP_BUS_SLVERR    2'b10
`endif

// File: src/tcop_pkg.sv
// types shared by the timer compare and single-pulse block
// assumes tcop_cfg.svh holds the numeric constants
package tcop_pkg;
  // operating mode of compare channel one
  typedef enum logic [2:0] {
    TCOP_MODE_COMPARE = 3'b001,
    TCOP_MODE_SPULSE  = 3'b010,
    TCOP_MODE_PWM     = 3'b100
  } tcop_mode_type;
endpackage : tcop_pkg

// File: src/tcop_prescale.sv
// timer count-enable generator: cpu clock divided, or external pin edges
// assumes the external clock pin is synchronous to aclk
`timescale 1ns/1ps
`include "tcop_cfg.svh"
module tcop_prescale #(
  parameter int DIV_W = 3
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clk_en,
  // selection
  input  wire logic [1:0] clock_select_field,
  input  wire logic       ext_clk,
  // count enable out
  output logic            tick
);
  if (DIV_W < 3) begin : g_bad_div
    $error("tcop_prescale: DIV_W must be at least 3");
  end

  logic [DIV_W-1:0] div_q;
  logic             ext_q;
  wire              ext_rise;
  wire              div_tick;

  // divider taps: 2, 4 or 8 cpu cycles per count
  assign div_tick = (clock_select_field == 2'b00) ? div_q[0] :
                    (clock_select_field == 2'b01) ? (&div_q[1:0]) :
                    (&div_q[2:0]);
  assign ext_rise = ext_clk & ~ext_q;
  assign tick = (clock_select_field == `TCOP_CKSEL_EXT) ? ext_rise
                                                        : div_tick;

  // free divider and external edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      ext_q <= 1'b0;
    end else if (clk_en) begin
      div_q <= div_q + 1'b1;
      ext_q <= ext_clk;
    end
  end
endmodule : tcop_prescale

// File: src/tcop_timer.sv
// timer compare, forced level and single-pulse section with bus slave
// assumes an axi4-lite master on aclk and pins synchronous to aclk
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tcop_cfg.svh"
module tcop_timer #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // pins
  input  wire logic              ext_clk,
  input  wire logic              trigger_capture_pin_one,
  input  wire logic              capture_pin_two,
  output logic                   compare_out_pin_one,
  output logic                   compare_out_pin_two,
  output logic                   compare_out_pin_one_oe_n,
  output logic                   compare_out_pin_two_oe_n,
  // shared interrupt request
  output logic                   timer_irq
);
  if (ADDR_W < 7) begin : g_bad_addr
    $error("tcop_timer: ADDR_W must be at least 7");
  end

  // decode an address to its register slot
  function automatic logic is_addr(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] r);
    is_addr = (a[ADDR_W-1:0] == ADDR_W'(r));
  endfunction : is_addr

  // state
  logic [15:0] cnt_q;
  logic [15:0] cmp1_q, cmp2_q, cap1_q, cap2_q;
  logic [7:0]  ctrl_a_q, ctrl_b_q;
  logic        gmask_q;
  logic        inh1_q, inh2_q;
  logic [3:0]  flag_q;
  logic [3:0]  armed_q;
  logic        pin1_q, pin2_q;
  logic        cap1_in_q, cap2_in_q;
  logic        aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;

  // count clock enable
  wire tick;
  tcop_prescale #(.DIV_W(3)) u_prescale (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .clk_en             (clk_en),
    .clock_select_field (ctrl_b_q[`TCOP_B_CKSEL_HI:`TCOP_B_CKSEL_LO]),
    .ext_clk            (ext_clk),
    .tick               (tick)
  );

  // mode selection: pwm wins when both selects are set
  tcop_pkg::tcop_mode_type mode;
  assign mode = ctrl_b_q[`TCOP_B_PWM]    ? tcop_pkg::TCOP_MODE_PWM :
                ctrl_b_q[`TCOP_B_SPULSE] ? tcop_pkg::TCOP_MODE_SPULSE
                                         : tcop_pkg::TCOP_MODE_COMPARE;
  wire spulse  = (mode == tcop_pkg::TCOP_MODE_SPULSE);
  wire normal  = (mode == tcop_pkg::TCOP_MODE_COMPARE);

  // edge detection on capture pins, polarity from control a
  wire edge1 = ctrl_a_q[`TCOP_A_EDGE1]
               ? (trigger_capture_pin_one & ~cap1_in_q)
               : (~trigger_capture_pin_one & cap1_in_q);
  wire edge2 = ctrl_a_q[`TCOP_A_EDGE2]
               ? (capture_pin_two & ~cap2_in_q)
               : (~capture_pin_two & cap2_in_q);
  wire trig  = spulse & edge1;
  wire cap1_ev = normal & edge1;
  wire cap2_ev = ~mode[2] & edge2;

  // matches pulse only on a tick while the count equals the value, taken once per count
  wire match1 = tick & ~inh1_q & (cnt_q == cmp1_q);
  wire match2 = tick & ~inh2_q & (cnt_q == cmp2_q);

  // bus handshake decode
  wire aw_ok  = aw_hold_q | s_axi_awvalid;
  wire w_ok   = w_hold_q | s_axi_wvalid;
  wire do_wr  = aw_ok & w_ok & ~bvalid_q;
  wire do_rd  = s_axi_arvalid & ~rvalid_q;
  wire [ADDR_W-1:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire        wlo = ws[0];
  wire [7:0]  ra = 8'(s_axi_araddr);
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // register write strobes; all but the capture low writes need the low byte lane
  wire wr_a    = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CTRL_A);
  wire wr_b    = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CTRL_B);
  wire wr_c1h  = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CMP1_HI);
  wire wr_c1l  = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CMP1_LO);
  wire wr_c2h  = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CMP2_HI);
  wire wr_c2l  = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CMP2_LO);
  wire wr_cpu  = do_wr & wlo & is_addr(wa, `TCOP_ADDR_CPUFLAGS);
  wire wr_cap1l = do_wr & is_addr(wa, `TCOP_ADDR_CAP1_LO);
  wire wr_cap2l = do_wr & is_addr(wa, `TCOP_ADDR_CAP2_LO);
  wire wr_any  = is_addr(wa, `TCOP_ADDR_CTRL_A) |
                 is_addr(wa, `TCOP_ADDR_CTRL_B) |
                 is_addr(wa, `TCOP_ADDR_CMP1_HI) |
                 is_addr(wa, `TCOP_ADDR_CMP1_LO) |
                 is_addr(wa, `TCOP_ADDR_CMP2_HI) |
                 is_addr(wa, `TCOP_ADDR_CMP2_LO) |
                 is_addr(wa, `TCOP_ADDR_CAP1_LO) |
                 is_addr(wa, `TCOP_ADDR_CAP2_LO) |
                 is_addr(wa, `TCOP_ADDR_CPUFLAGS);
  wire rd_stat = do_rd & (ra == `TCOP_ADDR_STATUS);

  // low byte accesses that complete a flag clear, per status bit
  wire [3:0] lo_acc;
  assign lo_acc[`TCOP_S_CAP1] = wr_cap1l |
                                (do_rd & (ra == `TCOP_ADDR_CAP1_LO));
  assign lo_acc[`TCOP_S_CAP2] = wr_cap2l |
                                (do_rd & (ra == `TCOP_ADDR_CAP2_LO));
  assign lo_acc[`TCOP_S_CMP1] = wr_c1l |
                                (do_rd & (ra == `TCOP_ADDR_CMP1_LO));
  assign lo_acc[`TCOP_S_CMP2] = wr_c2l |
                                (do_rd & (ra == `TCOP_ADDR_CMP2_LO));

  // hardware flag sets
  wire [3:0] flag_set;
  assign flag_set[`TCOP_S_CAP1] = cap1_ev | trig;
  assign flag_set[`TCOP_S_CAP2] = cap2_ev;
  assign flag_set[`TCOP_S_CMP1] = normal & match1;
  assign flag_set[`TCOP_S_CMP2] = ~mode[2] & match2;
  // set wins over a clear in the same cycle
  wire [3:0] flag_d = flag_set | (flag_q & ~(armed_q & lo_acc));
  wire [3:0] armed_d = (armed_q | (rd_stat ? flag_q : 4'h0)) & ~lo_acc;

  // read data mux
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ra)
      `TCOP_ADDR_CTRL_A:   rd_mux = {24'h00_0000, ctrl_a_q};
      `TCOP_ADDR_CTRL_B:   rd_mux = {24'h00_0000, ctrl_b_q};
      `TCOP_ADDR_STATUS:   rd_mux = {28'h000_0000, flag_q};
      `TCOP_ADDR_CMP1_HI:  rd_mux = {24'h00_0000, cmp1_q[15:8]};
      `TCOP_ADDR_CMP1_LO:  rd_mux = {24'h00_0000, cmp1_q[7:0]};
      `TCOP_ADDR_CMP2_HI:  rd_mux = {24'h00_0000, cmp2_q[15:8]};
      `TCOP_ADDR_CMP2_LO:  rd_mux = {24'h00_0000, cmp2_q[7:0]};
      `TCOP_ADDR_CAP1_HI:  rd_mux = {24'h00_0000, cap1_q[15:8]};
      `TCOP_ADDR_CAP1_LO:  rd_mux = {24'h00_0000, cap1_q[7:0]};
      `TCOP_ADDR_CAP2_HI:  rd_mux = {24'h00_0000, cap2_q[15:8]};
      `TCOP_ADDR_CAP2_LO:  rd_mux = {24'h00_0000, cap2_q[7:0]};
      `TCOP_ADDR_COUNT:    rd_mux = {16'h0000, cnt_q};
      `TCOP_ADDR_CPUFLAGS: rd_mux = {31'h0000_0000, gmask_q};
      default:             rd_hit = 1'b0;
    endcase
  end

  // bus channel state; one write and one read in flight at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TCOP_BUS_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TCOP_BUS_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_any ? `TCOP_BUS_OKAY : `TCOP_BUS_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_rd) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? `TCOP_BUS_OKAY : `TCOP_BUS_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // control registers and compare values; hardware never writes compares
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= 8'h00;
      ctrl_b_q <= 8'h00;
      gmask_q  <= 1'b1;
      cmp1_q   <= `TCOP_CMP_RESET;
      cmp2_q   <= `TCOP_CMP_RESET;
      inh1_q   <= 1'b0;
      inh2_q   <= 1'b0;
    end else if (clk_en) begin
      if (wr_a)   ctrl_a_q <= wd[7:0];
      if (wr_b)   ctrl_b_q <= wd[7:0];
      if (wr_cpu) gmask_q <= wd[0];
      if (wr_c1h) cmp1_q[15:8] <= wd[7:0];
      if (wr_c1l) cmp1_q[7:0] <= wd[7:0];
      if (wr_c2h) cmp2_q[15:8] <= wd[7:0];
      if (wr_c2l) cmp2_q[7:0] <= wd[7:0];
      if (wr_c1h) inh1_q <= 1'b1;
      else if (wr_c1l) inh1_q <= 1'b0;
      if (wr_c2h) inh2_q <= 1'b1;
      else if (wr_c2l) inh2_q <= 1'b0;
    end
  end

  // counter and captures; trigger restart takes priority over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= `TCOP_CNT_RELOAD;
      cap1_q    <= 16'h0000;
      cap2_q    <= 16'h0000;
      cap1_in_q <= 1'b0;
      cap2_in_q <= 1'b0;
    end else if (clk_en) begin
      cap1_in_q <= trigger_capture_pin_one;
      cap2_in_q <= capture_pin_two;
      if (trig) cnt_q <= `TCOP_CNT_RELOAD;
      else if (tick) cnt_q <= cnt_q + 16'h0001;
      if (trig) cap1_q <= `TCOP_CAP_TRIGGER;
      else if (cap1_ev) cap1_q <= cnt_q;
      if (cap2_ev) cap2_q <= cnt_q;
    end
  end

  // status flags with two-step clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q  <= 4'h0;
      armed_q <= 4'h0;
    end else if (clk_en) begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  // pin latches; force applies only in plain compare mode
  wire f1 = normal & wr_a & wd[`TCOP_A_FORCE1];
  wire f2 = normal & wr_a & wd[`TCOP_A_FORCE2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
    end else if (clk_en) begin
      if (trig) pin1_q <= ctrl_a_q[`TCOP_A_LVL2];
      else if (spulse & match1) pin1_q <= ctrl_a_q[`TCOP_A_LVL1];
      else if (f1) pin1_q <= wd[`TCOP_A_LVL1];
      else if (normal & match1 & ctrl_b_q[`TCOP_B_PIN1_EN])
        pin1_q <= ctrl_a_q[`TCOP_A_LVL1];
      if (f2) pin2_q <= wd[`TCOP_A_LVL2];
      else if (normal & match2 & ctrl_b_q[`TCOP_B_PIN2_EN])
        pin2_q <= ctrl_a_q[`TCOP_A_LVL2];
    end
  end

  // pins drive only when enabled; otherwise left as general i/o
  assign compare_out_pin_one = pin1_q;
  assign compare_out_pin_two = pin2_q;
  assign compare_out_pin_one_oe_n = ~ctrl_b_q[`TCOP_B_PIN1_EN];
  assign compare_out_pin_two_oe_n = ~ctrl_b_q[`TCOP_B_PIN2_EN];

  // shared request stays up while any enabled flag is set and the cpu mask bit is clear
  wire cap_req = ctrl_a_q[`TCOP_A_CAP_IE] &
                 (flag_q[`TCOP_S_CAP1] | flag_q[`TCOP_S_CAP2]);
  wire cmp_req = ctrl_a_q[`TCOP_A_CMP_IE] &
                 (flag_q[`TCOP_S_CMP1] | flag_q[`TCOP_S_CMP2]);
  assign timer_irq = ~gmask_q & (cap_req | cmp_req);
endmodule : tcop_timer

// File: testbench/tcop_timer_checker.sv
// port-level checker for the timer compare block
// assumes writes offer address and data in one cycle with wstrb bit 0 set
`timescale 1ns/1ps
module tcop_timer_checker #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              clk_en,
  // register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  // pins and interrupt
  input wire logic              trigger_capture_pin_one,
  input wire logic              compare_out_pin_one,
  input wire logic              compare_out_pin_two,
  input wire logic              compare_out_pin_one_oe_n,
  input wire logic              timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] ctla_q;
  logic [7:0] ctlb_q;
  logic       mask_q;
  wire logic  wr_take;
  // split address and data writes are not tracked by this shadow
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready && clk_en && s_axi_wstrb[0];
  // shadow of the control bits that steer pins and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctla_q <= 8'h00;
      ctlb_q <= 8'h00;
      mask_q <= 1'b1;
    end else if (wr_take) begin
      case (s_axi_awaddr[7:0])
        8'h00: ctla_q <= s_axi_wdata[7:0];
        8'h04: ctlb_q <= s_axi_wdata[7:0];
        8'h30: mask_q <= s_axi_wdata[0];
        default: ;
      endcase
    end
  end
  property p_pin_reset;
    !$past(aresetn) |-> !compare_out_pin_one && !compare_out_pin_two;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("compare pins not low after reset");
  property p_oe;
    compare_out_pin_one_oe_n == !ctlb_q[0];
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin one enable does not follow control b");
  property p_force;
    wr_take && s_axi_awaddr[7:0] == 8'h00 && s_axi_wdata[4] && ctlb_q[0]
      && ctlb_q[3:2] == 2'b00 |=> ##[0:2] compare_out_pin_one == ctla_q[0];
  endproperty
  a_force: assert property (p_force)
    else $error("forced level not copied to pin one");
  property p_trigger;
    ctlb_q[3:2] == 2'b10 && ctlb_q[0] && ctla_q[2]
      && $rose(trigger_capture_pin_one)
      |-> ##[1:4] compare_out_pin_one == ctla_q[1];
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger edge did not start the pulse");
  property p_irq_mask;
    timer_irq |-> !mask_q;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised while masked");
  property p_irq_src;
    timer_irq |-> ctla_q[7] || ctla_q[6];
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt raised with no enable set");
  property p_wr_answer;
    wr_take |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered on the next cycle");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered on the next cycle");
endmodule : tcop_timer_checker
bind tcop_timer tcop_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .trigger_capture_pin_one,
  .compare_out_pin_one, .compare_out_pin_two, .compare_out_pin_one_oe_n,
  .timer_irq
);

// File: testbench/tcop_pin_agent.sv
// pin-side partner: trigger source and pulse watcher on compare pin one
// assumes a one-cycle fire strobe from the bench, synchronous to aclk
`timescale 1ns/1ps
module tcop_pin_agent (
  // clock and command
  input  wire logic       aclk,
  input  wire logic       fire_one,
  // pins
  output logic            trigger_capture_pin_one,
  output logic            capture_pin_two,
  input  wire logic       compare_out_pin_one,
  // observation
  output logic [7:0]      pulse_count
);
  logic [2:0] hold_q = 3'h0;
  logic       last_q = 1'b0;
  // both capture pins rise together, so capture two is seen in pulse mode
  assign trigger_capture_pin_one = hold_q != 3'h0;
  assign capture_pin_two = hold_q != 3'h0;
  initial pulse_count = 8'h00;
  // hold the edge four cycles, long enough for any input synchroniser
  always @(posedge aclk) begin
    hold_q <= fire_one ? 3'h4 : hold_q - 3'(hold_q != 3'h0);
    last_q <= compare_out_pin_one;
    if (compare_out_pin_one && !last_q) pulse_count <= pulse_count + 8'h01;
  end
endmodule : tcop_pin_agent

// File: testbench/tcop_timer_bench.sv
// self-checking bench for the timer compare and single-pulse block
// assumes the pin agent partner and the bound port checker
`timescale 1ns/1ps
module tcop_timer_bench;
  logic        aclk, aresetn, clk_en, ext_clk, fire_one, timer_irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, capture_pin_two;
  logic        trigger_capture_pin_one, compare_out_pin_one;
  logic        compare_out_pin_two, compare_out_pin_one_oe_n;
  logic        compare_out_pin_two_oe_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pulse_count;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors, check_count;
  tcop_timer #(.ADDR_W(8)) uut (
    .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ext_clk, .trigger_capture_pin_one, .capture_pin_two,
    .compare_out_pin_one, .compare_out_pin_two, .compare_out_pin_one_oe_n,
    .compare_out_pin_two_oe_n, .timer_irq);
  tcop_pin_agent agent (.aclk, .fire_one, .trigger_capture_pin_one,
    .capture_pin_two, .compare_out_pin_one, .pulse_count);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // a wait that runs out is a mismatch and ends the run
  task automatic give_up;
    num_errors++;
    final_report();
  endtask : give_up
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = 2'b00);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 100) give_up();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er = 2'b00);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 100) give_up();
    rd_q = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(32'(rd_q[7:0]), 32'(e));
  endtask : rx
  // sel 0 watches compare pin one, sel 1 the interrupt
  task automatic wait_for(input logic sel, input logic v);
    int n;
    for (n = 0; n < 300 && (sel ? timer_irq : compare_out_pin_one) !== v;
         n++) begin
      @(posedge aclk);
    end
    if (n == 300) give_up();
  endtask : wait_for
  task automatic t_reset;
    rx(8'h0c, 8'h80);
    rx(8'h10, 8'h00);
    rx(8'h14, 8'h80);
    rx(8'h18, 8'h00);
    rd(8'h3c, 2'b10);
    wr(8'h08, 8'h00, 2'b10);
    chk(32'({compare_out_pin_one, compare_out_pin_two}), 32'h0);
    chk(32'(timer_irq), 32'h0);
  endtask : t_reset
  // compare one matches at 0060 while compare two sits half written
  task automatic t_match;
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h43);
    wr(8'h30, 8'h00);
    wr(8'h18, 8'h60);
    wr(8'h14, 8'h00);
    wr(8'h0c, 8'h00);
    rx(8'h08, 8'h00);
    wr(8'h10, 8'h60);
    wait_for(1'b0, 1'b1);
    rx(8'h08, 8'h04);
    chk(32'(timer_irq), 32'h1);
    chk(32'({compare_out_pin_one_oe_n, compare_out_pin_two_oe_n}), 32'h1);
    rx(8'h10, 8'h60);
    rx(8'h08, 8'h00);
    chk(32'(timer_irq), 32'h0);
    wr(8'h18, 8'h80);
    wait_for(1'b1, 1'b1);
    chk(32'(compare_out_pin_two), 32'h0);
    wr(8'h30, 8'h01);
    chk(32'(timer_irq), 32'h0);
    wr(8'h30, 8'h00);
    rx(8'h08, 8'h08);
    wr(8'h18, 8'h80);
    rx(8'h08, 8'h00);
  endtask : t_match
  task automatic t_force;
    wr(8'h00, 8'h50);
    rx(8'h08, 8'h00);
    chk(32'({compare_out_pin_one, timer_irq}), 32'h0);
    wr(8'h00, 8'h51);
    rx(8'h08, 8'h00);
    chk(32'({compare_out_pin_one, timer_irq}), 32'h2);
    wr(8'h00, 8'h50);
  endtask : t_force
  // pulse of 20 ticks: counter restarts at fffc, ends at 0010
  task automatic t_pulse;
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h10);
    wr(8'h04, 8'h09);
    wr(8'h00, 8'h9f);
    rx(8'h08, 8'h00);
    chk(32'(compare_out_pin_one), 32'h0);
    wr(8'h00, 8'h8e);
    @(posedge aclk);
    fire_one <= 1'b1;
    @(posedge aclk);
    fire_one <= 1'b0;
    wait_for(1'b0, 1'b1);
    rx(8'h08, 8'h03);
    chk(32'(timer_irq), 32'h1);
    rx(8'h1c, 8'hff);
    rx(8'h20, 8'hfd);
    rx(8'h08, 8'h02);
    wait_for(1'b0, 1'b0);
    rx(8'h08, 8'h02);
    chk(32'(pulse_count), 32'h3);
  endtask : t_pulse
  // count reads 32 edges apart at /8, then 3 external edges, then pwm+pulse
  task automatic t_clock;
    logic [15:0] c0;
    wr(8'h04, 8'h20);
    rd(8'h2c);
    c0 = rd_q[15:0];
    repeat (29) @(posedge aclk);
    rd(8'h2c);
    chk(32'(16'(rd_q[15:0] - c0)), 32'h4);
    wr(8'h04, 8'h30);
    rd(8'h2c);
    c0 = rd_q[15:0];
    repeat (3) begin
      @(posedge aclk) ext_clk <= 1'b1;
      @(posedge aclk) ext_clk <= 1'b0;
    end
    rd(8'h2c);
    chk(32'(16'(rd_q[15:0] - c0)), 32'h3);
    wr(8'h04, 8'h0d);
    @(posedge aclk) fire_one <= 1'b1;
    @(posedge aclk) fire_one <= 1'b0;
    repeat (8) @(posedge aclk);
    rx(8'h20, 8'hfd);
    chk(32'(pulse_count), 32'h3);
  endtask : t_clock
  initial begin
    num_errors = 0;
    check_count = 0;
    {aresetn, clk_en, ext_clk, fire_one} = 4'b0100;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_match();
    t_force();
    t_pulse();
    t_clock();
    final_report();
  end
endmodule : tcop_timer_bench
